// ===== rtl/ucic_pkg.sv
// constants and types of the microcontroller interrupt controller
package ucic_pkg;
  // io addresses
  localparam logic [7:0] P0_EN_ADDR  = 8'h04;
  localparam logic [7:0] P1_EN_ADDR  = 8'h05;
  localparam logic [7:0] P0_POL_ADDR = 8'h08;
  localparam logic [7:0] P1_POL_ADDR = 8'h09;
  localparam logic [7:0] GLOBAL_IRQ_ENABLE_REG_ADDR   = 8'h20;
  // source positions in the global enable and pending vectors
  localparam int FAST_BIT = 1;
  localparam int SLOW_BIT = 2;
  localparam int EP0_BIT  = 3;
  localparam int EP1_BIT  = 4;
  localparam int GPIO_BIT = 6;
  localparam int WAKE_BIT = 7;
  localparam logic [7:0] SRC_MASK  = 8'hde;
  localparam logic [7:0] REG_RESET = 8'h00;
  // entry timing in core cycles
  localparam logic [3:0] CALL_CYCLES = 4'ha;
  localparam logic [3:0] JMP_CYCLES  = 4'h5;
  localparam int         ENTRY_SPAN  = 16;
  typedef enum logic [1:0] {S_IDLE, S_CALL, S_JMP} ucic_state_type;
  typedef struct packed {
    logic [7:0]     p0_en;
    logic [7:0]     p1_en;
    logic [7:0]     p0_pol;
    logic [7:0]     p1_pol;
    logic [7:0]     global_irq_enable_reg;
    logic [7:0]     pend;
    logic [7:0]     rdata;
    logic [15:0]    pin_s1;
    logic [15:0]    pin_s2;
    logic           cx_s1;
    logic           cx_s2;
    logic           cx_prev;
    logic           or_prev;
    ucic_state_type st;
    logic [3:0]     cnt;
    logic [2:0]     win;
    logic           start;
  } ucic_regs_type;
endpackage

// ===== rtl/ucic_intc.sv
// interrupt latches, gpio edge logic, priority and entry sequencer
`timescale 1ns/1ns
module ucic_intc
  import ucic_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // io register port of the core
  input  wire logic [7:0]  io_addr,
  input  wire logic [7:0]  io_wdata,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  output logic      [7:0]  io_rdata,
  // asynchronous pins
  input  wire logic [7:0]  port0_pin,
  input  wire logic [7:0]  port1_pin,
  input  wire logic        cext_pin,
  // on-chip event pulses
  input  wire logic        fast_tick,
  input  wire logic        slow_tick,
  input  wire logic        ep0_out_done,
  input  wire logic        ep0_in_acked,
  input  wire logic        ep1_in_acked,
  // core handshake
  input  wire logic        instr_last,
  output logic             core_entry,
  output logic             entry_busy,
  output logic      [7:0]  vector_addr,
  output logic             handler_start
);
  ucic_regs_type r;
  ucic_regs_type next_r;
  logic [15:0] port_en;
  logic [15:0] port_pol;
  logic [15:0] pin_hit;
  logic        gpio_or;
  logic [7:0]  req;
  logic [2:0]  win_c;

  // lowest index wins, no entry for index 0 or 5
  function automatic logic [2:0] ucic_pick(input logic [7:0] v);
    logic [2:0] w;
    w = 3'h0;
    for (int i = 7; i >= 1; i--) begin
      if (v[i]) begin
        w = 3'(i);
      end
    end
    return w;
  endfunction

  // per-pin trigger detect, qualified by the pin enable
  assign port_en  = {r.p1_en, r.p0_en};
  assign port_pol = {r.p1_pol, r.p0_pol};
  for (genvar g = 0; g < 16; g++) begin : g_pin
    assign pin_hit[g] = ~(r.pin_s2[g] ^ port_pol[g])
                        & port_en[g];
  end
  assign gpio_or = |pin_hit;

  // requests and sampling point
  assign req        = r.pend & r.global_irq_enable_reg & SRC_MASK;
  assign win_c      = ucic_pick(req);
  assign core_entry = instr_last && (r.st == S_IDLE) && (|req);
  assign entry_busy = (r.st != S_IDLE);
  assign vector_addr   = {4'h0, r.win, 1'b0};
  assign handler_start = r.start;
  assign io_rdata      = r.rdata;

  // next state of every register
  always_comb begin
    logic [7:0] set_v;
    logic [7:0] clr_v;
    set_v = 8'h00;
    clr_v = 8'h00;
    next_r = r;
    next_r.start = 1'b0;
    // two-flop pin synchronisers, third stage for edges
    next_r.pin_s1  = {port1_pin, port0_pin};
    next_r.pin_s2  = r.pin_s1;
    next_r.cx_s1   = cext_pin;
    next_r.cx_s2   = r.cx_s1;
    next_r.cx_prev = r.cx_s2;
    next_r.or_prev = gpio_or;
    // register writes
    if (io_wr) begin
      if (io_addr == P0_EN_ADDR) begin
        next_r.p0_en = io_wdata;
      end
      if (io_addr == P1_EN_ADDR) begin
        next_r.p1_en = io_wdata;
      end
      if (io_addr == P0_POL_ADDR) begin
        next_r.p0_pol = io_wdata;
      end
      if (io_addr == P1_POL_ADDR) begin
        next_r.p1_pol = io_wdata;
      end
      if (io_addr == GLOBAL_IRQ_ENABLE_REG_ADDR) begin
        next_r.global_irq_enable_reg = io_wdata & SRC_MASK;
      end
    end
    // only the global enable reads back; write-only ones read zero
    if (io_rd) begin
      next_r.rdata = (io_addr == GLOBAL_IRQ_ENABLE_REG_ADDR) ? r.global_irq_enable_reg : 8'h00;
    end
    // source events
    set_v[FAST_BIT] = fast_tick;
    set_v[SLOW_BIT] = slow_tick;
    set_v[EP0_BIT]  = ep0_out_done | ep0_in_acked;
    set_v[EP1_BIT]  = ep1_in_acked;
    set_v[GPIO_BIT] = gpio_or & ~r.or_prev;
    set_v[WAKE_BIT] = r.cx_s2 & ~r.cx_prev;
    // entry sequencer
    unique case (r.st)
      S_IDLE: begin
        if (core_entry) begin
          next_r.global_irq_enable_reg = REG_RESET;
          next_r.win  = win_c;
          next_r.cnt  = CALL_CYCLES - 4'h1;
          next_r.st   = S_CALL;
        end
      end
      S_CALL: begin
        if (r.cnt == CALL_CYCLES - 4'h1) begin
          clr_v[r.win] = 1'b1;
          if (r.win == 3'(GPIO_BIT)) begin
            next_r.global_irq_enable_reg[GPIO_BIT] = 1'b0;
          end
        end
        if (r.cnt == 4'h0) begin
          next_r.cnt = JMP_CYCLES - 4'h1;
          next_r.st  = S_JMP;
        end else begin
          next_r.cnt = r.cnt - 4'h1;
        end
      end
      S_JMP: begin
        if (r.cnt == 4'h0) begin
          next_r.start = 1'b1;
          next_r.st    = S_IDLE;
        end else begin
          next_r.cnt = r.cnt - 4'h1;
        end
      end
    endcase
    // a new event beats the clear in the same cycle
    next_r.pend = ((r.pend & ~clr_v) | set_v) & SRC_MASK;
  end

  // state register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence entry_s;
    core_entry ##1 (r.st == S_CALL);
  endsequence
  sequence quiet_s;
    !handler_start [*8];
  endsequence

  entry_span_a: assert property (
    entry_s |-> ##(ENTRY_SPAN - 1) handler_start)
    else $error("handler start not 16 cycles after entry");
  entry_quiet_a: assert property (
    core_entry |=> quiet_s ##0 entry_busy)
    else $error("handler start too early");
  sample_point_a: assert property (
    core_entry |-> instr_last && $past(r.st) != S_CALL)
    else $error("entry outside last instruction cycle");
  global_irq_enable_reg_clear_a: assert property (
    core_entry && !(io_wr && io_addr == GLOBAL_IRQ_ENABLE_REG_ADDR) |=> r.global_irq_enable_reg == 8'h00)
    else $error("global enable not cleared on entry");
  gpio_fire_a: assert property (
    gpio_or && !r.or_prev |=> r.pend[GPIO_BIT])
    else $error("gpio flop not set on or rise");
  gpio_ack_a: assert property (
    (r.st == S_CALL && r.cnt == CALL_CYCLES - 4'h1
     && r.win == 3'(GPIO_BIT) && !(gpio_or && !r.or_prev))
    |=> !r.pend[GPIO_BIT] && !r.global_irq_enable_reg[GPIO_BIT])
    else $error("gpio acknowledge left flop or enable set");
  wake_latch_a: assert property (
    $rose(r.cx_s2) |=> r.pend[WAKE_BIT])
    else $error("wake pin rise not latched");
  prio_order_a: assert property (
    core_entry |-> (req & ((8'h01 << win_c) - 8'h01)) == 8'h00
                   && req[win_c])
    else $error("lower priority source won");
  en_keep_a: assert property (
    r.st == S_CALL && !io_wr |=> $stable(r.p0_en) && $stable(r.p1_en))
    else $error("pin enables changed during acknowledge");
  mask_gate_a: assert property (
    core_entry |-> r.global_irq_enable_reg[win_c] && r.pend[win_c])
    else $error("entry without enabled pending source");

  // entry phases: ten call cycles, five jump cycles, then the handler
  sequence call_s;
    (r.st == S_CALL) [*8] ##1 (r.st == S_CALL) [*2];
  endsequence
  sequence jmp_s;
    (r.st == S_JMP) [*5];
  endsequence
  sequence busy_s;
    entry_busy [*8] ##1 entry_busy [*7] ##1 !entry_busy;
  endsequence

  // call phase strictly before the jump phase
  entry_phase_a: assert property (
    core_entry |=> call_s ##1 jmp_s ##1 handler_start)
    else $error("entry phases out of order");

  // busy covers exactly the fifteen entry cycles
  busy_span_a: assert property (
    entry_s |-> busy_s)
    else $error("entry busy span wrong");

  // handler start is a single-cycle pulse
  start_pulse_a: assert property (
    handler_start |=> !handler_start)
    else $error("handler start longer than one cycle");

  // handler start comes with the sequencer back at rest
  start_idle_a: assert property (
    handler_start |-> !entry_busy)
    else $error("handler start while busy");

  // no second entry while one is in flight
  no_reentry_a: assert property (
    entry_busy |-> !core_entry)
    else $error("entry taken while busy");

  // a ready request is taken at the last instruction cycle
  entry_ready_a: assert property (
    instr_last && !entry_busy && (|req) |-> core_entry)
    else $error("ready request not taken");

  // never taken in the middle of an instruction
  entry_need_a: assert property (
    !instr_last |-> !core_entry)
    else $error("entry before last instruction cycle");

  // vector follows the winner of the entry edge
  vector_pick_a: assert property (
    core_entry |=> vector_addr == {4'h0, $past(win_c), 1'b0})
    else $error("vector does not match winner");

  // vector stands through the whole entry
  vector_hold_a: assert property (
    entry_busy |=> $stable(vector_addr))
    else $error("vector changed during entry");

  // reset slot and reserved slot are never entered
  vector_legal_a: assert property (
    core_entry |-> win_c != 3'h0 && win_c != 3'h5)
    else $error("entry to reserved vector");

  // enables are already clear in the first call cycle
  global_irq_enable_reg_zero_a: assert property (
    entry_s |-> r.global_irq_enable_reg == 8'h00)
    else $error("global enable not clear in call");

  // latch still set while enables clear: order kept
  latch_order_a: assert property (
    entry_s |-> r.pend[r.win])
    else $error("latch cleared before enables");

  // winner latch cleared one cycle into the call
  fast_clear_a: assert property (
    r.st == S_CALL && r.cnt == CALL_CYCLES - 4'h1
    && r.win == 3'(FAST_BIT) && !fast_tick |=> !r.pend[FAST_BIT])
    else $error("fast tick latch not cleared");

  // every event pulse sets its latch, set beats clear
  fast_set_a: assert property (
    fast_tick |=> r.pend[FAST_BIT])
    else $error("fast tick not latched");

  slow_set_a: assert property (
    slow_tick |=> r.pend[SLOW_BIT])
    else $error("slow tick not latched");

  ep0_set_a: assert property (
    ep0_out_done || ep0_in_acked |=> r.pend[EP0_BIT])
    else $error("endpoint 0 event not latched");

  ep1_set_a: assert property (
    ep1_in_acked |=> r.pend[EP1_BIT])
    else $error("endpoint 1 ack not latched");

  // latches do not set without their event
  ep0_quiet_a: assert property (
    !ep0_out_done && !ep0_in_acked && !r.pend[EP0_BIT]
    |=> !r.pend[EP0_BIT])
    else $error("endpoint 0 latch set without event");

  gpio_quiet_a: assert property (
    !(gpio_or && !r.or_prev) && !r.pend[GPIO_BIT] |=> !r.pend[GPIO_BIT])
    else $error("gpio latch set without or rise");

  wake_quiet_a: assert property (
    !(r.cx_s2 && !r.cx_prev) && !r.pend[WAKE_BIT] |=> !r.pend[WAKE_BIT])
    else $error("wake latch set without pin rise");

  // gpio flop reaches priority only through its global enable
  gpio_gate_a: assert property (
    !r.global_irq_enable_reg[GPIO_BIT] |-> !req[GPIO_BIT])
    else $error("gpio request without global enable");

  // reserved positions never hold a bit
  reserved_zero_a: assert property (
    (r.global_irq_enable_reg & ~SRC_MASK) == 8'h00 && (r.pend & ~SRC_MASK) == 8'h00)
    else $error("reserved enable or latch bit set");

  // pin enable write lands next cycle
  en_write_a: assert property (
    io_wr && io_addr == P0_EN_ADDR |=> r.p0_en == $past(io_wdata))
    else $error("pin enable write lost");

  // polarity write lands next cycle
  pol_write_a: assert property (
    io_wr && io_addr == P1_POL_ADDR |=> r.p1_pol == $past(io_wdata))
    else $error("polarity write lost");

  // write-only registers read back as zero
  read_zero_a: assert property (
    io_rd && io_addr != GLOBAL_IRQ_ENABLE_REG_ADDR |=> io_rdata == 8'h00)
    else $error("write-only register read back");

  // read data stands until the next read
  rdata_hold_a: assert property (
    !io_rd |=> $stable(io_rdata))
    else $error("read data changed without read");

  // pins reach the edge logic after exactly two flops
  pin_sync_a: assert property (
    r.pin_s2 == $past({port1_pin, port0_pin}, 2))
    else $error("pin synchroniser depth wrong");

  // no gpio detect counts without any pin enable bit
  pin_enable_a: assert property (
    gpio_or |-> |{r.p1_en, r.p0_en})
    else $error("gpio detect without any pin enable");
endmodule

// ===== tb/ucic_core_model.sv
// core partner model: three-cycle instructions, entry latency counter
`timescale 1ns/1ns
module ucic_core_model (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // core handshake
  input  wire logic core_entry,
  input  wire logic handler_start,
  output logic      instr_last,
  output int        lat
);
  int n = 0;
  int t0 = 0;
  // three-cycle instructions: last cycle every third edge
  assign instr_last = !rst && ((n % 3) == 2);
  // edges from the entry edge to the first handler instruction
  always @(posedge ref_clk) begin
    n <= n + 1;
    if (core_entry) t0 <= n;
    if (handler_start) lat <= n - t0;
  end
endmodule

// ===== tb/ucic_intc_tb.sv
// self-checking bench of the interrupt controller
`timescale 1ns/1ns
module ucic_intc_tb;
  import ucic_pkg::*;
  logic       ref_clk = 0, rst = 1, io_wr = 0, io_rd = 0, cext_pin = 0;
  logic       fast_tick = 0, slow_tick = 0, ep0_out_done = 0;
  logic       ep0_in_acked = 0, ep1_in_acked = 0;
  logic [7:0] io_addr = 0, io_wdata = 0, port0_pin = 0, port1_pin = 0;
  logic [7:0] io_rdata, vector_addr, v;
  logic       core_entry, entry_busy, handler_start, instr_last;
  int         lat, fails = 0, check_count = 0;
  ucic_intc uut (.ref_clk, .rst, .io_addr, .io_wdata, .io_wr, .io_rd,
    .io_rdata, .port0_pin, .port1_pin, .cext_pin, .fast_tick, .slow_tick,
    .ep0_out_done, .ep0_in_acked, .ep1_in_acked, .instr_last,
    .core_entry, .entry_busy, .vector_addr, .handler_start);
  ucic_core_model core (.ref_clk, .rst, .core_entry, .handler_start,
    .instr_last, .lat);
  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;
  // compare and count
  task chk(string nm, logic [7:0] got, logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // io bus write and read, driven at falling edges
  task wr(logic [7:0] a, logic [7:0] d);
    @(negedge ref_clk);
    io_addr = a; io_wdata = d; io_wr = 1;
    @(negedge ref_clk);
    io_wr = 0;
  endtask
  task rd(logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    io_addr = a; io_rd = 1;
    @(negedge ref_clk);
    io_rd = 0;
    d = io_rdata;
  endtask
  // one-cycle event pulse: fast, slow, ep0 out, ep0 in, ep1 in
  task pulse(logic [4:0] k);
    @(negedge ref_clk);
    {fast_tick, slow_tick, ep0_out_done, ep0_in_acked, ep1_in_acked} = k;
    @(negedge ref_clk);
    {fast_tick, slow_tick, ep0_out_done, ep0_in_acked, ep1_in_acked} = 0;
  endtask
  // enable, then wait for the handler and judge the entry
  task go(logic [7:0] g, logic [7:0] vec);
    wr(GLOBAL_IRQ_ENABLE_REG_ADDR, g);
    repeat (40) begin
      @(negedge ref_clk);
      if (handler_start === 1'b1) break;
    end
    chk("start", {7'h0, handler_start}, 8'h01);
    chk("vector", vector_addr, vec);
    @(negedge ref_clk);
    chk("latency", 8'(lat), 8'h10);
    rd(GLOBAL_IRQ_ENABLE_REG_ADDR, v);
    chk("global_irq_enable_reg cleared", v, 8'h00);
  endtask
  task t_regs;
    rd(GLOBAL_IRQ_ENABLE_REG_ADDR, v);
    chk("global_irq_enable_reg reset", v, 8'h00);
    wr(GLOBAL_IRQ_ENABLE_REG_ADDR, 8'hff);
    rd(GLOBAL_IRQ_ENABLE_REG_ADDR, v);
    chk("global_irq_enable_reg rw", v, 8'hde);
    wr(8'h33, 8'hff);
    rd(P0_EN_ADDR, v);
    chk("enable wo", v, 8'h00);
    wr(GLOBAL_IRQ_ENABLE_REG_ADDR, 8'h00);
  endtask
  task t_prio;
    pulse(5'h10); pulse(5'h08); pulse(5'h02); pulse(5'h01);
    for (int i = 1; i < 5; i++) go(8'h1e, 8'(2 * i));
    pulse(5'h04);
    go(8'h08, 8'h06);
  endtask
  task t_gpio;
    wr(P0_POL_ADDR, 8'h01);
    wr(P0_EN_ADDR, 8'h01);
    @(negedge ref_clk) port0_pin = 8'h01;
    go(8'h40, 8'h0c);
    chk("gpio source", port0_pin & 8'h01, 8'h01);
    wr(P1_EN_ADDR, 8'h01);
    wr(GLOBAL_IRQ_ENABLE_REG_ADDR, 8'h40);
    repeat (10) @(negedge ref_clk);
    rd(GLOBAL_IRQ_ENABLE_REG_ADDR, v);
    chk("gpio blocked", v, 8'h40);
    wr(GLOBAL_IRQ_ENABLE_REG_ADDR, 8'h00);
    wr(P1_EN_ADDR, 8'h00);
    wr(P0_EN_ADDR, 8'h00);
    wr(P0_EN_ADDR, 8'h01);
    go(8'h40, 8'h0c);
  endtask
  task t_wake;
    @(negedge ref_clk) cext_pin = 1;
    go(8'h80, 8'h0e);
  endtask
  // counts, verdict and end of run
  task print_verdict;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // watchdog against a hung entry
  initial begin
    #100000;
    fails++;
    print_verdict;
  end
  initial begin
    repeat (5) @(negedge ref_clk);
    rst = 0;
    t_regs;
    t_prio;
    t_gpio;
    t_wake;
    print_verdict;
  end
endmodule
